// ---- hdl/phy_mii_latency_timing.sv ----
// Transceiver MII datapath latency and clock edge timing model
// Function
// - 100M: start-of-stream J leaves about 5 bit times after TX_EN clock edge.
// - 100M: end-of-stream T leaves about 5 bit times after TX_EN drop edge.
// - Bit time is 10 ns at 100 Mb/s and 100 ns at 10 Mb/s.
// - Carrier sense rises 20 (TX) or 10 (FX) bit times after J.
// - Carrier sense falls 24 (TX) or 14 (FX) bits after T; data same latency.
// - 10M nibble mode: TXD and TX_EN sampled on TX_CLK falling edge.
// - Serial mode: TXD_0 and TX_EN launched and sampled on TX_CLK rise.
// - Serial mode: RXD_0 and RX_DV change on RX_CLK falling edge.
// - 10BASE-T line starts 3.5 bits after the sampling TX_CLK edge.
// - 10BASE-T packet end holds line high 300 ns typical, 250 ns least.
// - RX_CLK source switch may stretch a phase, never shorten one.
`timescale 1ns/1ps
`default_nettype none
module phy_mii_latency_timing
  import phy_lat_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mode straps
  input wire logic speed_100_pin,
  input wire logic fiber_pin,
  input wire logic serial_pin,
  // MAC transmit side
  input wire logic tx_clk_pin,
  input wire logic tx_en_pin,
  input wire logic [NIB_W-1:0] txd_pin,
  // Line receive side
  input wire logic line_rx_act_pin,
  input wire logic [NIB_W-1:0] line_rxd_pin,
  input wire logic line_rec_clk_pin,
  // Line transmit side
  output logic line_tx_active_r,
  output logic line_tx_end_r,
  output logic line_idle_high_r,
  output logic [NIB_W-1:0] line_txd_r,
  // MAC receive side
  output logic crs_r,
  output logic rx_dv_r,
  output logic [NIB_W-1:0] rxd_r,
  output logic rx_clk_r
);

  // Two-flop synchronisers, bit order: rec_clk, rx_act, tx_en, tx_clk, serial, fiber, speed
  localparam int SYN_W = 7 + 2 * NIB_W;
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syn1_r <= '0;
      syn2_r <= '0;
    end else begin
      syn1_r <= {line_rxd_pin, txd_pin, line_rec_clk_pin, line_rx_act_pin, tx_en_pin,
                 tx_clk_pin, serial_pin, fiber_pin, speed_100_pin};
      syn2_r <= syn1_r;
    end
  end

  logic speed_100_s, fiber_s, serial_s, tx_clk_s, tx_en_s, rx_act_s, rec_clk_s;
  logic [NIB_W-1:0] txd_s;
  logic [NIB_W-1:0] line_rxd_s;
  assign speed_100_s = syn2_r[0];
  assign fiber_s = syn2_r[1];
  assign serial_s = syn2_r[2] & ~syn2_r[0];
  assign tx_clk_s = syn2_r[3];
  assign tx_en_s = syn2_r[4];
  assign rx_act_s = syn2_r[5];
  assign rec_clk_s = syn2_r[6];
  assign txd_s = syn2_r[7 +: NIB_W];
  assign line_rxd_s = syn2_r[7 + NIB_W +: NIB_W];

  // TX_CLK edge detection on the synchronised level
  logic tx_clk_d_r;
  logic rec_clk_d_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_clk_d_r <= 1'b0;
      rec_clk_d_r <= 1'b0;
    end else begin
      tx_clk_d_r <= tx_clk_s;
      rec_clk_d_r <= rec_clk_s;
    end
  end
  logic tx_rise, tx_fall, smp_edge;
  assign tx_rise = tx_clk_s & ~tx_clk_d_r;
  assign tx_fall = ~tx_clk_s & tx_clk_d_r;
  // Nibble 10M samples on the fall, giving the MAC half a period of setup
  assign smp_edge = (speed_100_s | serial_s) ? tx_rise : tx_fall;

  // Sampled transmit enable and data
  logic tx_en_smp_r;
  logic [NIB_W-1:0] txd_smp_r;
  logic tx_start, tx_stop;
  assign tx_start = smp_edge & tx_en_s & ~tx_en_smp_r;
  assign tx_stop = smp_edge & ~tx_en_s & tx_en_smp_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_en_smp_r <= 1'b0;
      txd_smp_r <= '0;
    end else if (smp_edge) begin
      tx_en_smp_r <= tx_en_s;
      txd_smp_r <= serial_s ? {{(NIB_W-1){1'b0}}, txd_s[0]} : txd_s;
    end
  end

  // Start and end delays, one counter each so short frames cannot collide
  logic [CNT_W-1:0] sos_cnt_r;
  logic [CNT_W-1:0] eos_cnt_r;
  logic [CNT_W-1:0] sos_len;
  assign sos_len = speed_100_s ? CNT_W'(TX_SOS_CYC) : CNT_W'(TX_START_10_CYC);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sos_cnt_r <= CNT_ZERO;
    end else if (tx_start) begin
      sos_cnt_r <= sos_len;
    end else if (sos_cnt_r != CNT_ZERO) begin
      sos_cnt_r <= sos_cnt_r - CNT_ONE;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eos_cnt_r <= CNT_ZERO;
    end else if (tx_stop) begin
      eos_cnt_r <= CNT_W'(TX_EOS_CYC);
    end else if (eos_cnt_r != CNT_ZERO) begin
      eos_cnt_r <= eos_cnt_r - CNT_ONE;
    end
  end

  // Line transmit state
  logic sos_fire, eos_fire;
  assign sos_fire = sos_cnt_r == CNT_ONE;
  assign eos_fire = eos_cnt_r == CNT_ONE;
  logic [CNT_W-1:0] idle_cnt_r;
  logic line_tx_active_nxt;
  assign line_tx_active_nxt = sos_fire | (line_tx_active_r & ~eos_fire);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      line_tx_active_r <= 1'b0;
      line_tx_end_r <= 1'b0;
      line_txd_r <= '0;
    end else begin
      line_tx_end_r <= eos_fire;
      line_tx_active_r <= line_tx_active_nxt;
      // Data follows the next state, so no stale nibble trails the end
      line_txd_r <= line_tx_active_nxt ? txd_smp_r : '0;
    end
  end

  // End of packet high hold, same length whatever the last bit was
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idle_cnt_r <= CNT_ZERO;
      line_idle_high_r <= 1'b0;
    end else if (eos_fire && !speed_100_s) begin
      idle_cnt_r <= CNT_W'(EOP_HIGH_CYC);
      line_idle_high_r <= 1'b1;
    end else if (idle_cnt_r > CNT_ONE) begin
      idle_cnt_r <= idle_cnt_r - CNT_ONE;
    end else begin
      idle_cnt_r <= CNT_ZERO;
      line_idle_high_r <= 1'b0;
    end
  end

  // Receive carrier sense delays
  logic rx_act_d_r;
  logic [CNT_W-1:0] crs_cnt_r;
  logic rx_j, rx_t;
  assign rx_j = rx_act_s & ~rx_act_d_r;
  assign rx_t = ~rx_act_s & rx_act_d_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_act_d_r <= 1'b0;
      crs_cnt_r <= CNT_ZERO;
      crs_r <= 1'b0;
    end else begin
      rx_act_d_r <= rx_act_s;
      if (rx_j) begin
        crs_cnt_r <= fiber_s ? CNT_W'(CRS_ON_FX_CYC) : CNT_W'(CRS_ON_TX_CYC);
      end else if (rx_t) begin
        crs_cnt_r <= fiber_s ? CNT_W'(CRS_OFF_FX_CYC) : CNT_W'(CRS_OFF_TX_CYC);
      end else if (crs_cnt_r != CNT_ZERO) begin
        crs_cnt_r <= crs_cnt_r - CNT_ONE;
      end
      if (crs_cnt_r == CNT_ONE) begin
        crs_r <= rx_act_d_r;
      end
    end
  end

  // Receive data delay line, tap chosen to match carrier-off latency
  logic [NIB_W:0] pipe_r [PIPE_DEPTH];
  genvar g;
  generate
    for (g = 0; g < PIPE_DEPTH; g++) begin : g_pipe
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pipe_r[g] <= '0;
        end else if (g == 0) begin
          pipe_r[g] <= {rx_act_s, line_rxd_s};
        end else begin
          pipe_r[g] <= pipe_r[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate
  logic [NIB_W:0] rx_tap;
  assign rx_tap = fiber_s ? pipe_r[CRS_OFF_FX_CYC-1] : pipe_r[CRS_OFF_TX_CYC-1];

  // Receive clock, switching source only in the phase allowed to stretch
  logic rec_sel_r;
  logic [CNT_W-1:0] ph_cnt_r;
  logic stretch_lvl, ph_ok, rec_edge, rx_toggle, rx_fall;
  assign stretch_lvl = serial_s;
  assign ph_ok = ph_cnt_r >= CNT_W'(RXCLK_MIN_CYC - 1);
  assign rec_edge = rx_clk_r ? (~rec_clk_s & rec_clk_d_r) : (rec_clk_s & ~rec_clk_d_r);
  assign rx_toggle = ph_ok & (rec_sel_r ? rec_edge : ph_cnt_r >= CNT_W'(RXCLK_HALF_CYC - 1));
  assign rx_fall = rx_toggle & rx_clk_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rec_sel_r <= 1'b0;
      ph_cnt_r <= CNT_ZERO;
      rx_clk_r <= 1'b0;
    end else begin
      // A late switch lengthens the current phase only
      if (rx_clk_r == stretch_lvl) begin
        rec_sel_r <= rx_act_s;
      end
      if (rx_toggle) begin
        rx_clk_r <= ~rx_clk_r;
        ph_cnt_r <= CNT_ZERO;
      end else if (ph_cnt_r != {CNT_W{1'b1}}) begin
        ph_cnt_r <= ph_cnt_r + CNT_ONE;
      end
    end
  end

  // MII receive outputs: every cycle at 100M, on RX_CLK fall at 10M
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_dv_r <= 1'b0;
      rxd_r <= '0;
    end else if (speed_100_s || rx_fall) begin
      rx_dv_r <= rx_tap[NIB_W];
      rxd_r <= serial_s ? {{(NIB_W-1){1'b0}}, rx_tap[0]} : rx_tap[NIB_W-1:0];
    end
  end

endmodule : phy_mii_latency_timing
`default_nettype wire

// ---- inc/phy_lat_pkg.sv ----
// Constants for the transceiver datapath latency model
package phy_lat_pkg;
  // Clock of the model
  localparam int CLK_NS = 100;
  // Bit times
  localparam int BIT_100_NS = 10;
  localparam int BIT_10_NS = 100;
  // Latencies in tenths of a bit time
  localparam int TX_SOS_TENTHS = 50;
  localparam int TX_EOS_TENTHS = 50;
  localparam int CRS_ON_TX_TENTHS = 200;
  localparam int CRS_ON_FX_TENTHS = 100;
  localparam int CRS_OFF_TX_TENTHS = 240;
  localparam int CRS_OFF_FX_TENTHS = 140;
  localparam int TX_START_10_TENTHS = 35;
  // End of packet high time
  localparam int EOP_HIGH_MIN_NS = 250;
  localparam int EOP_HIGH_TYP_NS = 300;
  // Receive clock phases in ns
  localparam int RXCLK_HALF_NS = 200;
  localparam int RXCLK_MIN_NS = 160;

  // Rounds up to whole cycles, never below one
  function automatic int cyc_up(input int tenths, input int bit_ns);
    int c;
    c = (tenths * bit_ns + 10 * CLK_NS - 1) / (10 * CLK_NS);
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int TX_SOS_CYC = cyc_up(TX_SOS_TENTHS, BIT_100_NS);
  localparam int TX_EOS_CYC = cyc_up(TX_EOS_TENTHS, BIT_100_NS);
  localparam int CRS_ON_TX_CYC = cyc_up(CRS_ON_TX_TENTHS, BIT_100_NS);
  localparam int CRS_ON_FX_CYC = cyc_up(CRS_ON_FX_TENTHS, BIT_100_NS);
  localparam int CRS_OFF_TX_CYC = cyc_up(CRS_OFF_TX_TENTHS, BIT_100_NS);
  localparam int CRS_OFF_FX_CYC = cyc_up(CRS_OFF_FX_TENTHS, BIT_100_NS);
  localparam int TX_START_10_CYC = cyc_up(TX_START_10_TENTHS, BIT_10_NS);
  localparam int EOP_HIGH_CYC = cyc_up(10 * EOP_HIGH_TYP_NS, 1);
  localparam int RXCLK_HALF_CYC = cyc_up(10 * RXCLK_HALF_NS, 1);
  localparam int RXCLK_MIN_CYC = cyc_up(10 * RXCLK_MIN_NS, 1);

  // Widths
  localparam int CNT_W = 4;
  localparam int NIB_W = 4;
  localparam int PIPE_DEPTH = CRS_OFF_TX_CYC;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
endpackage : phy_lat_pkg

// ---- testbench/mac_model.sv ----
// MAC side model: makes TX_CLK and launches frames on its rise
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  // Clock and request
  input wire logic ref_clk,
  input wire logic send,
  // MII transmit
  output logic tx_clk_pin = 1'b0,
  output logic tx_en_pin = 1'b0,
  output logic [3:0] txd_pin = 4'h0
);
  logic [2:0] ph_r = 3'h0;
  always @(posedge ref_clk) begin
    #1;
    ph_r = ph_r + 3'h1;
    tx_clk_pin = ph_r[2];
    if (ph_r == 3'h4) begin
      tx_en_pin = send;
      // Idle lines show the inverse, never a stale nibble
      txd_pin = send ? txd_pin + 4'h3 : ~txd_pin;
    end
  end
endmodule : mac_model
`default_nettype wire

// ---- testbench/phy_lat_sva.sv ----
// Timing assertions on the transceiver model ports
`timescale 1ns/1ps
`default_nettype none
module phy_lat_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Straps and line
  input wire logic speed_100_pin,
  input wire logic fiber_pin,
  input wire logic line_rx_act_pin,
  // Watched outputs
  input wire logic line_tx_active_r,
  input wire logic line_tx_end_r,
  input wire logic line_idle_high_r,
  input wire logic [3:0] line_txd_r,
  input wire logic crs_r,
  input wire logic [3:0] rxd_r,
  input wire logic rx_clk_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_end_pulse_one: assert property (line_tx_end_r |=> !line_tx_end_r)
    else $error("end pulse");
  a_idle_hold: assert property (
    $rose(line_idle_high_r) |-> line_idle_high_r[*3] ##1 !line_idle_high_r) else $error("eop");
  a_txd_quiet: assert property (!line_tx_active_r |-> line_txd_r == 4'h0)
    else $error("txd idle");
  a_crs_on_tx: assert property (
    $rose(line_rx_act_pin) && speed_100_pin && !fiber_pin |-> !crs_r[*4] ##[1:3] crs_r)
    else $error("crs on tx");
  a_crs_on_fx: assert property (
    $rose(line_rx_act_pin) && speed_100_pin && fiber_pin |-> !crs_r[*3] ##[1:3] crs_r)
    else $error("crs on fx");
  a_crs_off_tx: assert property (
    $fell(line_rx_act_pin) && speed_100_pin && !fiber_pin |-> crs_r[*4] ##[1:3] !crs_r)
    else $error("crs off tx");
  a_crs_off_fx: assert property (
    $fell(line_rx_act_pin) && speed_100_pin && fiber_pin |-> crs_r[*3] ##[1:3] !crs_r)
    else $error("crs off fx");
  a_rx_on_fall: assert property (
    !speed_100_pin && rxd_r != $past(rxd_r) |-> $fell(rx_clk_r)) else $error("rxd edge");
  a_rxclk_phase: assert property ($changed(rx_clk_r) |=> $stable(rx_clk_r))
    else $error("rx clk phase");
  c_tx: cover property ($rose(line_tx_active_r));
  c_fx: cover property ($rose(crs_r) && fiber_pin);
  c_eop: cover property ($rose(line_idle_high_r));
endmodule : phy_lat_sva
bind phy_mii_latency_timing phy_lat_sva u_sva (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .speed_100_pin(speed_100_pin),
  .fiber_pin(fiber_pin),
  .line_rx_act_pin(line_rx_act_pin),
  .line_tx_active_r(line_tx_active_r),
  .line_tx_end_r(line_tx_end_r),
  .line_idle_high_r(line_idle_high_r),
  .line_txd_r(line_txd_r),
  .crs_r(crs_r),
  .rxd_r(rxd_r),
  .rx_clk_r(rx_clk_r)
);
`default_nettype wire

// ---- testbench/phy_mii_latency_timing_bench.sv ----
// Self-checking bench for the transceiver timing model
`timescale 1ns/1ps
`default_nettype none
module phy_mii_latency_timing_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic speed_100_pin = 1'b1;
  logic fiber_pin = 1'b0;
  logic serial_pin = 1'b0;
  logic send = 1'b0;
  logic line_rx_act_pin = 1'b0;
  logic [3:0] line_rxd_pin = 4'h0;
  logic line_rec_clk_pin = 1'b0;
  logic tx_clk_pin, tx_en_pin, line_tx_active_r, line_tx_end_r, line_idle_high_r;
  logic crs_r, rx_dv_r, rx_clk_r;
  logic [3:0] txd_pin, line_txd_r, rxd_r;
  logic [3:0] txd_first = 4'h0;
  logic [3:0] line_first = 4'h0;
  logic [5:0] w_q = 6'h0;
  int up [6];
  int dn [6];
  int cyc = 0;
  int n_idle = 0;
  int n_rxh = 0;
  int fails = 0;
  int num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  mac_model u_mac (
    .ref_clk(ref_clk),
    .send(send),
    .tx_clk_pin(tx_clk_pin),
    .tx_en_pin(tx_en_pin),
    .txd_pin(txd_pin)
  );
  phy_mii_latency_timing u_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .speed_100_pin(speed_100_pin),
    .fiber_pin(fiber_pin),
    .serial_pin(serial_pin),
    .tx_clk_pin(tx_clk_pin),
    .tx_en_pin(tx_en_pin),
    .txd_pin(txd_pin),
    .line_rx_act_pin(line_rx_act_pin),
    .line_rxd_pin(line_rxd_pin),
    .line_rec_clk_pin(line_rec_clk_pin),
    .line_tx_active_r(line_tx_active_r),
    .line_tx_end_r(line_tx_end_r),
    .line_idle_high_r(line_idle_high_r),
    .line_txd_r(line_txd_r),
    .crs_r(crs_r),
    .rx_dv_r(rx_dv_r),
    .rxd_r(rxd_r),
    .rx_clk_r(rx_clk_r)
  );
  // Stamps taken mid-cycle, so sync lag cancels in differences
  always @(negedge ref_clk) begin
    logic [5:0] w;
    w = {rx_dv_r, crs_r, line_rx_act_pin, line_tx_end_r, line_tx_active_r, tx_en_pin};
    cyc++;
    for (int i = 0; i < 6; i++) begin
      if (w[i] === 1'b1 && w_q[i] === 1'b0) up[i] = cyc;
      if (w[i] === 1'b0 && w_q[i] === 1'b1) dn[i] = cyc;
    end
    // First nibble launched with the enable, and first nibble put on the line
    if (w[0] === 1'b1 && w_q[0] === 1'b0) txd_first = txd_pin;
    if (w[1] === 1'b1 && w_q[1] === 1'b0) line_first = line_txd_r;
    w_q = w;
    n_idle += int'(line_idle_high_r === 1'b1);
    n_rxh += int'(rx_clk_r === 1'b1);
  end
  always @(posedge ref_clk) begin
    #1;
    if (cyc % 2 == 0) line_rec_clk_pin = ~line_rec_clk_pin;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic tx_frame(input logic s100, input logic ser, output int a, output int e);
    logic [3:0] m;
    m = (ser && !s100) ? 4'h1 : 4'hF;
    speed_100_pin = s100;
    serial_pin = ser;
    n_idle = 0;
    step(20);
    send = 1'b1;
    step(32);
    send = 1'b0;
    step(30);
    a = up[1] - up[0];
    e = up[2] - dn[0];
    chk("first nibble", line_first, txd_first & m);
  endtask : tx_frame
  task automatic test_tx;
    int a1, e1, a2, e2, a3, e3;
    tx_frame(1'b1, 1'b0, a1, e1);
    chk("sos 100M", int'(a1 >= 3 && a1 <= 6), 1);
    chk("eos 100M", e1, a1);
    tx_frame(1'b0, 1'b0, a2, e2);
    chk("sos nibble", a2 - a1, 7);
    chk("eos nibble", e2 - e1, 4);
    tx_frame(1'b0, 1'b1, a3, e3);
    chk("sos serial", a3 - a1, 3);
    chk("eos serial", e3, e1);
    chk("eop high", n_idle, 3);
    $display("test_tx done");
  endtask : test_tx
  task automatic rx_frame(input logic fx, input logic s100, output int o, output int f);
    speed_100_pin = s100;
    fiber_pin = fx;
    step(20);
    line_rx_act_pin = 1'b1;
    line_rxd_pin = 4'h5;
    step(24);
    chk("rx data", rxd_r, (serial_pin && !s100) ? 4'h1 : 4'h5);
    line_rx_act_pin = 1'b0;
    line_rxd_pin = 4'h0;
    step(20);
    o = up[4] - up[3];
    f = dn[4] - dn[3];
  endtask : rx_frame
  task automatic test_rx;
    int o1, f1, o2, f2;
    rx_frame(1'b0, 1'b1, o1, f1);
    chk("data lat TX", dn[5] - dn[3], f1);
    rx_frame(1'b1, 1'b1, o2, f2);
    chk("data lat FX", dn[5] - dn[3], f2);
    chk("crs on step", o1 - o2, 1);
    chk("crs off step", f1 - f2, 1);
    chk("crs off TX", f1 - o1, 1);
    serial_pin = 1'b1;
    n_rxh = 0;
    rx_frame(1'b0, 1'b0, o1, f1);
    chk("rx clk in 10M", int'(n_rxh > 10), 1);
    n_rxh = 0;
    step(8);
    chk("rx clk high", n_rxh, 4);
    $display("test_rx done");
  endtask : test_rx
  initial begin
    step(20);
    rst_n = 1'b1;
    step(5);
    test_tx;
    test_rx;
    report_and_stop;
  end
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule : phy_mii_latency_timing_bench
`default_nettype wire
